// File: src/i2c_ms_pkg.sv
// Shared constants and state type for the two-wire master sequencer
package i2c_ms_pkg;
  localparam int          RELOAD_W  = 7;      // Rate reload value width
  localparam int          DATA_W    = 8;      // Shift buffer width
  localparam logic [3:0]  ACK_SLOT  = 4'h8;   // Bit index of the ninth clock
  localparam logic [3:0]  FIRST_BIT = 4'h0;   // Bit index of the MSB
  localparam logic [3:0]  LAST_BIT  = 4'h7;   // Bit index of the LSB
  localparam logic [7:0]  BUF_RST   = 8'h00;  // Shift buffer reset value
  localparam logic        DRIVE_LVL = 1'b0;   // Level driven when enabled

  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ST_A = 4'h1,
    S_ST_B = 4'h2,
    S_RS_A = 4'h3,
    S_RS_B = 4'h4,
    S_RS_C = 4'h5,
    S_RS_D = 4'h6,
    S_TX_L = 4'h7,
    S_TX_H = 4'h8,
    S_AK_L = 4'h9,
    S_AK_H = 4'ha,
    S_SP_A = 4'hb,
    S_SP_B = 4'hc,
    S_SP_C = 4'hd,
    S_SP_D = 4'he,
    S_SP_E = 4'hf
  } seq_state_t;
endpackage : i2c_ms_pkg

// File: src/rate_counter.sv
// Bit period down-counter giving a one-cycle tick per period
`timescale 1ns/1ps
`default_nettype none
module rate_counter #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             go,
  input  wire logic [WIDTH-1:0] reload,
  // Period end
  output logic                  tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  // Reload while idle or at zero, else count down
  always_comb
  begin
    tick     = go && (cnt_reg == '0);
    cnt_next = cnt_reg;
    if (!go || tick)
      cnt_next = reload;
    else
      cnt_next = cnt_reg - 1'b1;
  end

  // Count register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : rate_counter
`default_nettype wire

// File: src/i2c_master_ack_stop_arbitration.sv
// Two-wire master: start, restart, byte, acknowledge, stop and arbitration
// Contract
// RULE_01: Ack enable pulls SCL low and puts the ack data value on SDA.
// RULE_02: Ack waits a period, releases SCL, counts once high, pulls low.
// RULE_03: Buffer write during ack or stop sets write collision, buffer kept.
// RULE_04: Stop enable with SCL held low drives SDA low.
// RULE_05: SDA seen low: count, release SCL, one period later release SDA.
// RULE_06: SDA rising with SCL high sets stop flag; period later irq.
// RULE_07: Completed byte wakes a sleeping core only if irq enabled.
// RULE_08: Reset or disable stops the port and ends any transfer.
// RULE_09: Start and stop flags clear on reset and while disabled.
// RULE_10: Bus free after stop or both flags clear; stop interrupts.
// RULE_11: Sending a one but reading zero flags collision, goes idle.
// RULE_12: Collision in transmit clears buffer full and releases both lines.
// RULE_13: Collision in a condition aborts it and clears its enable.
// RULE_14: After collision keep watching; a stop sets the port irq.
// RULE_15: After collision a new write restarts from the first bit.
// RULE_16: SDA or SCL low when start begins flags collision.
// RULE_17: Start counts once SDA high; SCL low meanwhile is a collision.
// RULE_18: Early SDA low restarts count; SCL low in second count is fine.
// RULE_19: Restart counts, releases SCL, SDA low once SCL high collides.
// RULE_20: Restart second count: SDA fall fine, SCL fall collides.
// RULE_21: Restart timeout drives SDA low, then SCL low after a count.
// RULE_22: Stop counts once SCL high; SCL low or late SDA low collides.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_ack_stop_arbitration #(
  parameter int RELOAD_W = i2c_ms_pkg::RELOAD_W
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // Bus pins
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe_n,
  // Control
  input  wire logic                port_enable,
  input  wire logic                port_irq_enable,
  input  wire logic                sleep_mode,
  input  wire logic [RELOAD_W-1:0] rate_reload_value,
  input  wire logic                start_req,
  input  wire logic                rstart_req,
  input  wire logic                stop_req,
  input  wire logic                ack_req,
  input  wire logic                ack_data_value,
  input  wire logic                buf_wr,
  input  wire logic [7:0]          buf_wr_data,
  input  wire logic                write_collision_clr,
  input  wire logic                collision_irq_clr,
  input  wire logic                port_irq_clr,
  // Status
  output logic                     start_seq_enable,
  output logic                     rstart_seq_enable,
  output logic                     stop_seq_enable,
  output logic                     ack_seq_enable,
  output logic                     write_collision_flag,
  output logic                     collision_irq_flag,
  output logic                     port_irq_flag,
  output logic                     buffer_full_flag,
  output logic                     start_detected,
  output logic                     stop_detected,
  output logic                     ack_status,
  output logic                     wake_req,
  output logic [7:0]               shift_buffer
);
  i2c_ms_pkg::seq_state_t st_reg, st_next;
  logic       sda_m_reg, sda_s_reg, sda_d_reg, scl_m_reg, scl_s_reg;
  logic       scl_d_reg;
  logic       sda_rel_reg, sda_rel_next, scl_rel_reg, scl_rel_next;
  logic       st_en_reg, st_en_next, rs_en_reg, rs_en_next;
  logic       sp_en_reg, sp_en_next, ak_en_reg, ak_en_next;
  logic       wr_coll_reg, wr_coll_next, bcol_reg, bcol_next;
  logic       pirq_reg, pirq_next, full_reg, full_next;
  logic       sflag_reg, sflag_next, pflag_reg, pflag_next;
  logic       akst_reg, akst_next, lost_reg, lost_next;
  logic       wake_reg, wake_next;
  logic [7:0] buf_reg, buf_next;
  logic [3:0] bit_reg, bit_next;
  logic       rate_go, tick, coll, pirq_set, wr_ok, bus_start, bus_stop;

  // Bit of the byte at an index; the ack slot reads as released
  function automatic logic bit_at(input logic [7:0] b, input logic [3:0] i);
    bit_at = (i < i2c_ms_pkg::ACK_SLOT) ? b[3'(i2c_ms_pkg::LAST_BIT - i)]
                                        : 1'b1;
  endfunction : bit_at

  rate_counter #(
    .WIDTH (RELOAD_W)
  ) u_rate (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .go      (rate_go),
    .reload  (rate_reload_value),
    .tick    (tick)
  );

  // Bus conditions seen on synchronised lines
  assign bus_start = sda_d_reg && !sda_s_reg && scl_s_reg && scl_d_reg;
  assign bus_stop  = !sda_d_reg && sda_s_reg && scl_s_reg && scl_d_reg;
  assign wr_ok     = (st_reg == i2c_ms_pkg::S_IDLE) && !full_reg && !start_req
                     && !rstart_req && !stop_req && !ack_req;

  // Sequencer next state
  always_comb
  begin
    st_next = st_reg;   sda_rel_next = sda_rel_reg; scl_rel_next = scl_rel_reg;
    st_en_next = st_en_reg; rs_en_next = rs_en_reg;
    sp_en_next = sp_en_reg; ak_en_next = ak_en_reg;
    full_next = full_reg; buf_next = buf_reg; bit_next = bit_reg;
    akst_next = akst_reg; lost_next = lost_reg;
    rate_go = 1'b0;     coll = 1'b0;          pirq_set = 1'b0;
    unique case (st_reg)
      i2c_ms_pkg::S_IDLE:
        if (start_req)
        begin
          st_en_next = 1'b1;
          lost_next  = 1'b0;
          if (!sda_s_reg || !scl_s_reg)
            coll = 1'b1;                                   // [RULE_16]
          else
            st_next = i2c_ms_pkg::S_ST_A;
        end
        else if (rstart_req)
        begin
          rs_en_next   = 1'b1;
          scl_rel_next = 1'b0;
          sda_rel_next = 1'b1;
          st_next      = i2c_ms_pkg::S_RS_A;
        end
        else if (stop_req)
        begin
          sp_en_next   = 1'b1;
          scl_rel_next = 1'b0;
          sda_rel_next = 1'b0;                             // [RULE_04]
          st_next      = i2c_ms_pkg::S_SP_A;
        end
        else if (ack_req)
        begin
          ak_en_next   = 1'b1;
          scl_rel_next = 1'b0;
          sda_rel_next = ack_data_value;                   // [RULE_01]
          st_next      = i2c_ms_pkg::S_AK_L;
        end
        else if (buf_wr && wr_ok)
        begin
          buf_next     = buf_wr_data;
          full_next    = 1'b1;
          bit_next     = i2c_ms_pkg::FIRST_BIT;            // [RULE_15]
          scl_rel_next = 1'b0;
          sda_rel_next = bit_at(buf_wr_data, i2c_ms_pkg::FIRST_BIT);
          st_next      = i2c_ms_pkg::S_TX_L;
        end
      i2c_ms_pkg::S_ST_A:
      begin
        rate_go = 1'b1;                                    // [RULE_17]
        if (!scl_s_reg)
          coll = 1'b1;                                     // [RULE_17]
        else if (!sda_s_reg || tick)
        begin
          rate_go      = sda_s_reg;                        // [RULE_18]
          sda_rel_next = 1'b0;
          st_next      = i2c_ms_pkg::S_ST_B;
        end
      end
      i2c_ms_pkg::S_ST_B:
      begin
        rate_go = 1'b1;
        if (tick)
        begin
          scl_rel_next = 1'b0;                             // [RULE_18]
          st_en_next   = 1'b0;
          pirq_set     = 1'b1;
          st_next      = i2c_ms_pkg::S_IDLE;
        end
      end
      i2c_ms_pkg::S_RS_A:
      begin
        rate_go = !scl_s_reg && sda_s_reg;                 // [RULE_19]
        if (tick)
        begin
          scl_rel_next = 1'b1;
          st_next      = i2c_ms_pkg::S_RS_B;
        end
      end
      i2c_ms_pkg::S_RS_B:
        if (scl_s_reg)
        begin
          if (!sda_s_reg)
            coll = 1'b1;                                   // [RULE_19]
          else
            st_next = i2c_ms_pkg::S_RS_C;
        end
      i2c_ms_pkg::S_RS_C:
      begin
        rate_go = 1'b1;                                    // [RULE_20]
        if (!sda_s_reg || (tick && scl_s_reg))
        begin
          rate_go      = sda_s_reg;
          sda_rel_next = 1'b0;                             // [RULE_21]
          st_next      = i2c_ms_pkg::S_RS_D;
        end
        else if (!scl_s_reg)
          coll = 1'b1;                                     // [RULE_20]
      end
      i2c_ms_pkg::S_RS_D:
      begin
        rate_go = 1'b1;
        if (tick)
        begin
          scl_rel_next = 1'b0;                             // [RULE_21]
          rs_en_next   = 1'b0;
          pirq_set     = 1'b1;
          st_next      = i2c_ms_pkg::S_IDLE;
        end
      end
      i2c_ms_pkg::S_TX_L, i2c_ms_pkg::S_AK_L:
      begin
        rate_go = 1'b1;                                    // [RULE_02]
        if (tick)
        begin
          scl_rel_next = 1'b1;
          st_next      = (st_reg == i2c_ms_pkg::S_TX_L) ? i2c_ms_pkg::S_TX_H
                                                         : i2c_ms_pkg::S_AK_H;
        end
      end
      i2c_ms_pkg::S_TX_H:
      begin
        rate_go = scl_s_reg;
        if (scl_s_reg && !sda_s_reg && bit_reg < i2c_ms_pkg::ACK_SLOT
            && bit_at(buf_reg, bit_reg))
          coll = 1'b1;                                     // [RULE_11]
        else if (tick)
        begin
          scl_rel_next = 1'b0;
          if (bit_reg == i2c_ms_pkg::ACK_SLOT)
          begin
            akst_next = sda_s_reg;
            pirq_set  = 1'b1;
            st_next   = i2c_ms_pkg::S_IDLE;
          end
          else
          begin
            bit_next     = bit_reg + 4'h1;
            sda_rel_next = bit_at(buf_reg, bit_reg + 4'h1);
            full_next    = (bit_reg == i2c_ms_pkg::LAST_BIT) ? 1'b0 : full_reg;
            st_next      = i2c_ms_pkg::S_TX_L;
          end
        end
      end
      i2c_ms_pkg::S_AK_H:
      begin
        rate_go = scl_s_reg;                               // [RULE_02]
        if (scl_s_reg && ack_data_value && !sda_s_reg)
          coll = 1'b1;
        else if (tick)
        begin
          scl_rel_next = 1'b0;                             // [RULE_02]
          ak_en_next   = 1'b0;
          st_next      = i2c_ms_pkg::S_IDLE;
        end
      end
      i2c_ms_pkg::S_SP_A:
      begin
        rate_go = !sda_s_reg;                              // [RULE_05]
        if (tick)
        begin
          scl_rel_next = 1'b1;
          st_next      = i2c_ms_pkg::S_SP_B;
        end
      end
      i2c_ms_pkg::S_SP_B:
        if (scl_s_reg)
          st_next = i2c_ms_pkg::S_SP_C;
      i2c_ms_pkg::S_SP_C:
      begin
        rate_go = 1'b1;                                    // [RULE_22]
        if (!scl_s_reg)
          coll = 1'b1;                                     // [RULE_22]
        else if (tick)
        begin
          sda_rel_next = 1'b1;                             // [RULE_05]
          st_next      = i2c_ms_pkg::S_SP_D;
        end
      end
      i2c_ms_pkg::S_SP_D:
      begin
        rate_go = 1'b1;
        if (tick && !sda_s_reg)
          coll = 1'b1;                                     // [RULE_22]
        else if (tick)
          st_next = i2c_ms_pkg::S_SP_E;
      end
      i2c_ms_pkg::S_SP_E:
      begin
        rate_go = 1'b1;
        if (tick)
        begin
          sp_en_next = 1'b0;                               // [RULE_06]
          pirq_set   = 1'b1;
          st_next    = i2c_ms_pkg::S_IDLE;
        end
      end
    endcase
    // Collision: abort, release lines, drop enables and buffer full
    if (coll)
    begin
      st_next      = i2c_ms_pkg::S_IDLE;                   // [RULE_11]
      sda_rel_next = 1'b1;                                 // [RULE_12]
      scl_rel_next = 1'b1;
      full_next    = 1'b0;
      st_en_next   = 1'b0;                                 // [RULE_13]
      rs_en_next   = 1'b0;
      sp_en_next   = 1'b0;
      ak_en_next   = 1'b0;
      lost_next    = 1'b1;
    end
    // Bus stop seen by the monitor while enabled or after a lost bus
    if (bus_stop && (port_irq_enable || lost_reg))
      pirq_set = 1'b1;                                     // [RULE_10] [RULE_14]
    // Disabled port ends everything
    if (!port_enable)
    begin
      st_next      = i2c_ms_pkg::S_IDLE;                   // [RULE_08]
      sda_rel_next = 1'b1;
      scl_rel_next = 1'b1;
      full_next    = 1'b0;
      st_en_next   = 1'b0;
      rs_en_next   = 1'b0;
      sp_en_next   = 1'b0;
      ak_en_next   = 1'b0;
      rate_go      = 1'b0;
      pirq_set     = 1'b0;
      coll         = 1'b0;
    end
  end

  // Status flags; a set in the clear cycle wins
  always_comb
  begin
    wr_coll_next = (buf_wr && !wr_ok) || (wr_coll_reg && !write_collision_clr);
    bcol_next  = coll || (bcol_reg && !collision_irq_clr);
    pirq_next  = pirq_set || (pirq_reg && !port_irq_clr);
    sflag_next = port_enable && (bus_start || (sflag_reg && !bus_stop));
    pflag_next = port_enable && (bus_stop || (pflag_reg && !bus_start));
    wake_next  = pirq_set && port_irq_enable && sleep_mode;
  end

  // Pin synchronisers and all state registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
      {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
      st_reg    <= i2c_ms_pkg::S_IDLE;                     // [RULE_08]
      sda_rel_reg <= 1'b1;
      scl_rel_reg <= 1'b1;
      {st_en_reg, rs_en_reg, sp_en_reg, ak_en_reg} <= 4'h0;
      {wr_coll_reg, bcol_reg, pirq_reg, full_reg} <= 4'h0;
      {sflag_reg, pflag_reg} <= 2'h0;                      // [RULE_09]
      {akst_reg, lost_reg, wake_reg} <= 3'h0;
      buf_reg   <= i2c_ms_pkg::BUF_RST;
      bit_reg   <= i2c_ms_pkg::FIRST_BIT;
    end
    else
    begin
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      st_reg    <= st_next;
      sda_rel_reg <= sda_rel_next;
      scl_rel_reg <= scl_rel_next;
      {st_en_reg, rs_en_reg} <= {st_en_next, rs_en_next};
      {sp_en_reg, ak_en_reg} <= {sp_en_next, ak_en_next};
      {wr_coll_reg, bcol_reg} <= {wr_coll_next, bcol_next}; // [RULE_03]
      {pirq_reg, full_reg}   <= {pirq_next, full_next};
      {sflag_reg, pflag_reg} <= {sflag_next, pflag_next};  // [RULE_06]
      {akst_reg, lost_reg}   <= {akst_next, lost_next};
      wake_reg  <= wake_next;                              // [RULE_07]
      buf_reg   <= buf_next;
      bit_reg   <= bit_next;
    end
  end

  // Drive levels are constants; all other outputs straight from registers
  assign sda_out  = i2c_ms_pkg::DRIVE_LVL;
  assign scl_out  = i2c_ms_pkg::DRIVE_LVL;
  assign sda_oe_n = sda_rel_reg;
  assign scl_oe_n = scl_rel_reg;
  assign {start_seq_enable, rstart_seq_enable} = {st_en_reg, rs_en_reg};
  assign {stop_seq_enable, ack_seq_enable}     = {sp_en_reg, ak_en_reg};
  assign write_collision_flag = wr_coll_reg;
  assign collision_irq_flag   = bcol_reg;
  assign port_irq_flag        = pirq_reg;
  assign buffer_full_flag     = full_reg;
  assign start_detected       = sflag_reg;
  assign stop_detected        = pflag_reg;
  assign ack_status           = akst_reg;
  assign wake_req             = wake_reg;
  assign shift_buffer         = buf_reg;

  // Checks on the sequencer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_ack_drive_lines: assert property (st_reg == i2c_ms_pkg::S_AK_L |-> // [RULE_01]
    !scl_oe_n && sda_oe_n == ack_data_value && ack_seq_enable)
    else $error("ack phase lines wrong");
  a_ack_end_idle: assert property (port_enable && !coll &&   // [RULE_02]
    st_reg == i2c_ms_pkg::S_AK_H && tick |=> !ack_seq_enable && !scl_oe_n
    && st_reg == i2c_ms_pkg::S_IDLE)
    else $error("ack end wrong");
  a_write_collision_flag_busy_write: assert property (buf_wr && !wr_ok |=>   // [RULE_03]
    write_collision_flag && shift_buffer == $past(shift_buffer))
    else $error("busy write not refused");
  a_stop_sda_low: assert property (st_reg == i2c_ms_pkg::S_SP_A |->  // [RULE_04]
    !sda_oe_n && !scl_oe_n)
    else $error("stop phase sda not driven");
  a_stop_release_order: assert property ($rose(sda_oe_n) &&  // [RULE_05]
    st_reg == i2c_ms_pkg::S_SP_D |-> scl_oe_n ##1 scl_oe_n)
    else $error("sda released before scl");
  a_disable_clears: assert property (!port_enable |=>        // [RULE_09]
    !start_detected && !stop_detected && st_reg == i2c_ms_pkg::S_IDLE)
    else $error("disable did not clear");
  a_coll_release: assert property ($rose(collision_irq_flag) |-> // [RULE_12]
    sda_oe_n && scl_oe_n && !buffer_full_flag
    && st_reg == i2c_ms_pkg::S_IDLE)
    else $error("collision left lines driven");
  a_coll_enables: assert property ($rose(collision_irq_flag) |-> // [RULE_13]
    !start_seq_enable && !rstart_seq_enable && !stop_seq_enable
    && !ack_seq_enable)
    else $error("collision left an enable set");
  a_start_busy_abort: assert property (port_enable &&        // [RULE_16]
    st_reg == i2c_ms_pkg::S_IDLE && start_req && !(scl_s_reg && sda_s_reg)
    |=> collision_irq_flag && !start_seq_enable)
    else $error("start on low bus not aborted");
  a_tx_arb_lost: assert property (port_enable &&             // [RULE_11]
    st_reg == i2c_ms_pkg::S_TX_H && scl_s_reg && !sda_s_reg && !sda_oe_n == 1'b0
    && bit_reg < i2c_ms_pkg::ACK_SLOT |=> collision_irq_flag)
    else $error("lost arbitration not flagged");
  a_wake_gated: assert property (wake_req |->                // [RULE_07]
    $past(port_irq_enable) && $past(sleep_mode) && port_irq_flag)
    else $error("wake without enable");

  c_start_done: cover property (st_reg == i2c_ms_pkg::S_ST_B && tick);
  c_stop_done: cover property (st_reg == i2c_ms_pkg::S_SP_E && tick);
  c_ack_done: cover property (st_reg == i2c_ms_pkg::S_AK_H && tick);
  c_collision: cover property ($rose(collision_irq_flag));
endmodule : i2c_master_ack_stop_arbitration
`default_nettype wire

// File: verif/bus_partner.sv
// Open-drain bus with pull-ups and a far-side party that can pull lines
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  // Device pin enables
  input  wire logic sda_oe_n,
  input  wire logic scl_oe_n,
  // Far-side commands
  input  wire logic pull_sda,
  input  wire logic hold_scl,
  // Resolved line levels
  output logic      sda_line,
  output logic      scl_line
);
  // Released lines float high; any party may pull low
  assign sda_line = sda_oe_n & ~pull_sda;
  assign scl_line = scl_oe_n & ~hold_scl;
endmodule : bus_partner
`default_nettype wire

// File: verif/test_i2c_master_ack_stop_arbitration.sv
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_ack_stop_arbitration;
  logic       ref_clk = 1'b0, nrst = 1'b0, sda_in, scl_in, sda_out, scl_out;
  logic       port_enable = 1'b1, port_irq_enable = 1'b0, sleep_mode = 1'b0;
  logic [6:0] rate_reload_value = 7'h03;
  logic       start_req = 1'b0, rstart_req = 1'b0, stop_req = 1'b0;
  logic       ack_req = 1'b0, ack_data_value = 1'b0, buf_wr = 1'b0;
  logic [7:0] buf_wr_data = 8'h00, shift_buffer;
  logic       write_collision_clr = 1'b0, collision_irq_clr = 1'b0;
  logic       port_irq_clr = 1'b0, pull_sda = 1'b0, hold_scl = 1'b0;
  logic       sda_oe_n, scl_oe_n, start_seq_enable, rstart_seq_enable;
  logic       stop_seq_enable, ack_seq_enable, write_collision_flag;
  logic       collision_irq_flag, port_irq_flag, buffer_full_flag;
  logic       start_detected, stop_detected, ack_status, wake_req;
  logic       woke = 1'b0;
  int         fail_count = 0, checks = 0, i;

  // Clock and wake pulse catcher
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wake_req === 1'b1) woke <= 1'b1;

  i2c_master_ack_stop_arbitration dut (
    .ref_clk, .nrst, .sda_in, .sda_out, .sda_oe_n, .scl_in, .scl_out,
    .scl_oe_n, .port_enable, .port_irq_enable, .sleep_mode,
    .rate_reload_value, .start_req, .rstart_req, .stop_req, .ack_req,
    .ack_data_value, .buf_wr, .buf_wr_data, .write_collision_clr,
    .collision_irq_clr, .port_irq_clr, .start_seq_enable,
    .rstart_seq_enable, .stop_seq_enable, .ack_seq_enable,
    .write_collision_flag, .collision_irq_flag, .port_irq_flag,
    .buffer_full_flag, .start_detected, .stop_detected, .ack_status,
    .wake_req, .shift_buffer);
  bus_partner far_side (.sda_oe_n, .scl_oe_n, .pull_sda, .hold_scl,
    .sda_line(sda_in), .scl_line(scl_in));

  // Compare and count
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // Pulse all three flag clears
  task clr_all;
    @(posedge ref_clk);
    {write_collision_clr, collision_irq_clr, port_irq_clr} <= 3'h7;
    @(posedge ref_clk);
    {write_collision_clr, collision_irq_clr, port_irq_clr} <= 3'h0;
  endtask : clr_all

  task t_start;
    @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    #1;
    for (i = 0; i < 300 && start_seq_enable !== 1'b0; i++) @(posedge ref_clk);
    #1;
    chk({sda_oe_n, scl_oe_n, collision_irq_flag}, 8'h00);
    chk({port_irq_flag, start_detected}, 8'h03);
  endtask : t_start

  // Lost arbitration on a one, then a fresh byte from its first bit
  task t_byte;
    @(posedge ref_clk);
    pull_sda <= 1'b1;
    buf_wr <= 1'b1;
    buf_wr_data <= 8'hff;
    @(posedge ref_clk);
    buf_wr <= 1'b0;
    for (i = 0; i < 300 && collision_irq_flag !== 1'b1; i++)
      @(posedge ref_clk);
    #1;
    chk(collision_irq_flag, 1'b1);
    chk({buffer_full_flag, sda_oe_n, scl_oe_n}, 8'h03);
    clr_all;
    @(posedge ref_clk);
    pull_sda <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(port_irq_flag, 1'b1);
    clr_all;
    @(posedge ref_clk);
    {sleep_mode, port_irq_enable, buf_wr} <= 3'h7;
    buf_wr_data <= 8'h7f;
    @(posedge ref_clk);
    buf_wr <= 1'b0;
    #1;
    chk({buffer_full_flag, sda_oe_n}, 8'h02);
    for (i = 0; i < 600 && port_irq_flag !== 1'b1; i++) @(posedge ref_clk);
    #1;
    chk(woke, 1'b1);
    chk({ack_status, buffer_full_flag, shift_buffer}, 10'h27f);
  endtask : t_byte

  // Both acknowledge values, with a buffer write refused meanwhile
  task t_ack;
    int v;
    for (v = 0; v < 2; v++)
    begin
      clr_all;
      @(posedge ref_clk);
      ack_req <= 1'b1;
      ack_data_value <= v[0];
      @(posedge ref_clk);
      {ack_req, buf_wr} <= 2'h1;
      buf_wr_data <= 8'h11;
      @(posedge ref_clk);
      buf_wr <= 1'b0;
      #1;
      chk({ack_seq_enable, scl_oe_n, sda_oe_n}, {2'h2, v[0]});
      chk({write_collision_flag, shift_buffer}, 9'h17f);
      for (i = 0; i < 300 && ack_seq_enable !== 1'b0; i++)
        @(posedge ref_clk);
      #1;
      chk({scl_oe_n, collision_irq_flag}, 8'h00);
    end
  endtask : t_ack

  // Repeated start from a held clock
  task t_restart;
    clr_all;
    @(posedge ref_clk);
    rstart_req <= 1'b1;
    @(posedge ref_clk);
    rstart_req <= 1'b0;
    #1;
    chk({rstart_seq_enable, scl_oe_n}, 8'h02);
    for (i = 0; i < 300 && rstart_seq_enable !== 1'b0; i++)
      @(posedge ref_clk);
    #1;
    chk({sda_oe_n, scl_oe_n, collision_irq_flag}, 8'h00);
    chk({port_irq_flag, start_detected, sda_out, scl_out}, 8'h0c);
  endtask : t_restart

  task t_stop;
    clr_all;
    @(posedge ref_clk);
    stop_req <= 1'b1;
    @(posedge ref_clk);
    stop_req <= 1'b0;
    #1;
    chk({stop_seq_enable, sda_oe_n}, 8'h02);
    for (i = 0; i < 300 && stop_seq_enable !== 1'b0; i++) @(posedge ref_clk);
    #1;
    chk({sda_oe_n, scl_oe_n, collision_irq_flag}, 8'h06);
    chk({stop_detected, port_irq_flag}, 8'h03);
    chk(start_detected, 1'b0);
  endtask : t_stop

  // Start on a held line, bus stop afterwards, then disable mid-byte
  task t_start_low;
    clr_all;
    @(posedge ref_clk);
    pull_sda <= 1'b1;
    repeat (3) @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    #1;
    chk({collision_irq_flag, start_seq_enable}, 8'h02);
    @(posedge ref_clk);
    {pull_sda, port_irq_clr} <= 2'h1;
    @(posedge ref_clk);
    port_irq_clr <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({port_irq_flag, stop_detected}, 8'h03);
    @(posedge ref_clk);
    buf_wr <= 1'b1;
    @(posedge ref_clk);
    buf_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    port_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({buffer_full_flag, sda_oe_n, scl_oe_n}, 8'h03);
    chk({start_detected, stop_detected}, 8'h00);
  endtask : t_start_low

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1;
    chk({sda_oe_n, scl_oe_n, collision_irq_flag, stop_detected}, 8'h0c);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_start;
    t_byte;
    t_ack;
    t_restart;
    t_stop;
    t_start_low;
    give_verdict;
  end

  // Watchdog
  initial
  begin
    repeat (8000) @(posedge ref_clk);
    fail_count++;
    give_verdict;
  end
endmodule : test_i2c_master_ack_stop_arbitration
`default_nettype wire
